// ==== core/udma_crc_and_busy_timing.sv ====
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module udma_crc_and_busy_timing
    import ucbt_pkg::*;
#(
    parameter logic [TMR_W-1:0] READY_CYCLES     = TMR_W'(READY_CYC_DEF),
    parameter logic [TMR_W-1:0] DOUT_IDLE_CYCLES = TMR_W'(DOUT_IDLE_CYC_DEF),
    parameter logic [TMR_W-1:0] DOUT_STBY_CYCLES = TMR_W'(DOUT_STBY_CYC_DEF),
    parameter logic [TMR_W-1:0] SEC_FIRST_CYCLES = TMR_W'(SEC_FIRST_CYC_DEF)
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              ata_reset_n,
    input  wire logic              dmack_n,
    input  wire logic              stop,
    input  wire logic              hstrobe,
    input  wire logic [DATA_W-1:0] dd_in,
    output logic                   dmarq,
    output logic                   intrq,
    output logic                   irq
);
    // Pin synchronisation
    logic [SYNC_W-1:0] pins_s;

    ucbt_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST_VAL)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({ata_reset_n, dmack_n, stop, hstrobe, dd_in}),
        .sync_out (pins_s)
    );

    wire               hrst_act = ~pins_s[SY_RST];
    wire               ack_act  = ~pins_s[SY_ACK];
    wire               stop_s   = pins_s[SY_STOP];
    wire               stb_s    = pins_s[SY_STB];
    wire [DATA_W-1:0]  dd_s     = pins_s[DATA_W-1:0];

    // CRC engine
    ucbt_crc_if crc_bus ();

    ucbt_crc_engine u_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .crc     (crc_bus.engine)
    );

    // State
    ucbt_state_type     state_q;
    ucbt_state_type     state_d;
    logic [TMR_W-1:0]   cnt_q;
    logic [TMR_W-1:0]   cnt_d;
    logic [TMR_W-1:0]   lim_q;
    logic               lim_en_q;
    logic               dma_q;
    logic               first_cmd_q;
    logic               err_q;
    logic               crc_bad_q;
    logic [DATA_W-1:0]  host_crc_q;
    logic               stby_q;
    logic               burst_q;
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic               stb_q;
    logic               ack_q;
    logic               term_q;
    logic               dmarq_q;
    logic               intrq_q;
    logic               irq_q;
    logic [DATA_W-1:0]  rdata_q;

    // Register port decode
    wire               wr_cmd    = reg_wr & (reg_addr == ADDR_COMMAND);
    wire               wr_ctrl   = reg_wr & (reg_addr == ADDR_CTRL);
    wire               wr_istat  = reg_wr & (reg_addr == ADDR_IRQ_STAT);
    wire               wr_imask  = reg_wr & (reg_addr == ADDR_IRQ_MASK);
    wire               rd_status = reg_rd & (reg_addr == ADDR_STATUS);
    wire [7:0]         cmd_code  = reg_wdata[7:0];

    wire               st_busy  = (state_q == ST_BUSY);
    wire               bsy      = (state_q != ST_IDLE);
    wire               drdy     = (state_q == ST_IDLE);

    // Commands written while busy are dropped, as on a real task file
    wire               cmd_take = wr_cmd & (state_q == ST_IDLE) & ~hrst_act;
    wire               done_req = wr_ctrl & reg_wdata[CTRL_DONE_BIT];
    wire               sec_first = first_cmd_q & is_security(cmd_code);
    wire               dout_cmd  = is_data_out(cmd_code);

    // Deadline picked at command accept
    wire [TMR_W-1:0]   lim_d = sec_first ? SEC_FIRST_CYCLES :
                               stby_q    ? DOUT_STBY_CYCLES :
                                           DOUT_IDLE_CYCLES;
    wire               lim_en_d = sec_first | dout_cmd;

    // Completion one cycle early so INTRQ lands on the deadline
    wire               tmo_hit  = st_busy & lim_en_q & (cnt_q >= lim_q - 1'b1);
    wire               complete = st_busy & (done_req | tmo_hit);
    wire               ready_hit = (cnt_q >= READY_CYCLES - 1'b1);

    // Burst tracking
    wire               stb_edge    = stb_s ^ stb_q;
    wire               burst_start = ack_act & ~ack_q;
    wire               burst_end   = ~ack_act & ack_q;
    wire               host_term   = ack_act & stop_s;
    // Edges after either side's termination carry no data
    wire               data_edge   = stb_edge & ack_act & ack_q & dmarq_q &
                                     ~stop_s & ~term_q;
    wire               crc_miss    = burst_end & (dd_s != crc_bus.state);
    wire               term_d      = ack_act & (term_q | stop_s);
    wire               dmarq_d     = st_busy & dma_q & burst_q & ~term_q & ~host_term;

    assign crc_bus.init   = burst_start;
    assign crc_bus.update = data_edge;
    assign crc_bus.data   = dd_s;

    // Interrupt status: set beats write-one clear
    wire [IRQ_W-1:0]   irq_set;
    wire [IRQ_W-1:0]   irq_clr  = wr_istat ? reg_wdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0]   irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

    assign irq_set[IRQ_DONE_BIT]  = complete;
    assign irq_set[IRQ_CRC_BIT]   = crc_miss;
    assign irq_set[IRQ_TMO_BIT]   = tmo_hit;
    assign irq_set[IRQ_BURST_BIT] = burst_end;

    // Read data selection
    wire [7:0]         status_byte = {bsy, drdy, 5'h00, err_q};
    wire [DATA_W-1:0]  ctrl_word   = {13'h0000, 1'b0, burst_q, stby_q};
    wire [DATA_W-1:0]  rd_mux =
        (reg_addr == ADDR_STATUS)   ? {8'h00, status_byte} :
        (reg_addr == ADDR_CTRL)     ? ctrl_word :
        (reg_addr == ADDR_IRQ_STAT) ? {12'h000, irq_stat_q} :
        (reg_addr == ADDR_IRQ_MASK) ? {12'h000, irq_mask_q} :
        (reg_addr == ADDR_CRC)      ? crc_bus.state :
        (reg_addr == ADDR_HOST_CRC) ? host_crc_q :
                                      16'h0000;

    // Command state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (ready_hit) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmd_take) begin
                    state_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (complete) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        // Hard reset reaches BSY three cycles after the pin falls
        if (hrst_act) begin
            state_d = ST_RESET;
        end
    end

    // Shared timer restarts on every state change and saturates
    assign cnt_d = (hrst_act || (state_d != state_q)) ? '0 :
                   (&cnt_q)                           ? cnt_q :
                                                        cnt_q + 1'b1;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Per-command context
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lim_q       <= '0;
            lim_en_q    <= 1'b0;
            dma_q       <= 1'b0;
            first_cmd_q <= 1'b1;
        end else if (hrst_act) begin
            lim_en_q    <= 1'b0;
            dma_q       <= 1'b0;
            first_cmd_q <= 1'b1;
        end else if (cmd_take) begin
            lim_q       <= lim_d;
            lim_en_q    <= lim_en_d;
            dma_q       <= is_dma(cmd_code);
            first_cmd_q <= 1'b0;
        end
    end

    // Error flag: CRC mismatch only surfaces when the command ends
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            crc_bad_q <= 1'b0;
            err_q     <= 1'b0;
        end else if (hrst_act || cmd_take) begin
            crc_bad_q <= 1'b0;
            err_q     <= 1'b0;
        end else begin
            if (crc_miss) begin
                crc_bad_q <= 1'b1;
            end
            if (complete) begin
                err_q <= crc_bad_q | crc_miss | tmo_hit;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            host_crc_q <= '0;
        end else if (burst_end) begin
            host_crc_q <= dd_s;
        end
    end

    // Link edge and burst tracking
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stb_q   <= 1'b0;
            ack_q   <= 1'b0;
            term_q  <= 1'b0;
            dmarq_q <= 1'b0;
        end else begin
            stb_q   <= stb_s;
            ack_q   <= ack_act;
            term_q  <= term_d;
            dmarq_q <= dmarq_d;
        end
    end

    // Per-burst interrupts are suppressed, only completion raises it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            intrq_q <= 1'b0;
        end else if (hrst_act) begin
            intrq_q <= 1'b0;
        end else if (complete) begin
            intrq_q <= 1'b1;
        end else if (rd_status || cmd_take) begin
            intrq_q <= 1'b0;
        end
    end

    // Control and interrupt registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stby_q  <= 1'b0;
            burst_q <= 1'b0;
        end else if (wr_ctrl) begin
            stby_q  <= reg_wdata[CTRL_STBY_BIT];
            burst_q <= reg_wdata[CTRL_BURST_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q      <= |(irq_stat_q & irq_mask_q);
            if (wr_imask) begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign dmarq     = dmarq_q;
    assign intrq     = intrq_q;
    assign irq       = irq_q;
endmodule

// ==== core/ucbt_pkg.sv ====
package ucbt_pkg;
    // Clock and timing figures
    localparam int     CLK_PERIOD_NS     = 50;
    localparam longint CLK_HZ            = 20_000_000;
    localparam int     HRST_BSY_MAX_NS   = 400;
    localparam int     HRST_BSY_MAX_CYC  = HRST_BSY_MAX_NS / CLK_PERIOD_NS;
    localparam int     CMD_BSY_MAX_NS    = 400;
    localparam int     CMD_BSY_MAX_CYC   = CMD_BSY_MAX_NS / CLK_PERIOD_NS;
    localparam longint READY_MAX_S       = 31;
    localparam longint DOUT_IDLE_MAX_S   = 10;
    localparam longint DOUT_STBY_MAX_S   = 25;
    localparam longint SEC_FIRST_MAX_S   = 10;
    localparam longint READY_CYC_DEF     = READY_MAX_S * CLK_HZ;
    localparam longint DOUT_IDLE_CYC_DEF = DOUT_IDLE_MAX_S * CLK_HZ;
    localparam longint DOUT_STBY_CYC_DEF = DOUT_STBY_MAX_S * CLK_HZ;
    localparam longint SEC_FIRST_CYC_DEF = SEC_FIRST_MAX_S * CLK_HZ;

    // Widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int TMR_W  = 32;
    localparam int IRQ_W  = 4;

    // CRC start value for every burst
    localparam logic [DATA_W-1:0] CRC_INIT = 16'h4ABA;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_COMMAND  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_CRC      = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_HOST_CRC = 4'h6;

    // Field positions
    localparam int ST_BSY_BIT     = 7;
    localparam int ST_DRDY_BIT    = 6;
    localparam int ST_ERR_BIT     = 0;
    localparam int CTRL_STBY_BIT  = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_DONE_BIT  = 2;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_CRC_BIT    = 1;
    localparam int IRQ_TMO_BIT    = 2;
    localparam int IRQ_BURST_BIT  = 3;

    // Command codes
    localparam logic [7:0] CMD_READ_DMA      = 8'hC8;
    localparam logic [7:0] CMD_WRITE_DMA     = 8'hCA;
    localparam logic [7:0] CMD_READ_DMA_EXT  = 8'h25;
    localparam logic [7:0] CMD_WRITE_DMA_EXT = 8'h35;
    localparam logic [7:0] CMD_WRITE_SECT    = 8'h30;
    localparam logic [7:0] CMD_WRITE_SECT_EX = 8'h34;
    localparam logic [7:0] CMD_SEC_SET_PW    = 8'hF1;
    localparam logic [7:0] CMD_SEC_UNLOCK    = 8'hF2;
    localparam logic [7:0] CMD_SEC_ERASE     = 8'hF4;
    localparam logic [7:0] CMD_SEC_DIS_PW    = 8'hF6;

    // Synchroniser bundle layout
    localparam int                SYNC_W       = 20;
    localparam int                SY_RST       = 19;
    localparam int                SY_ACK       = 18;
    localparam int                SY_STOP      = 17;
    localparam int                SY_STB       = 16;
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 20'hC_0000;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_IDLE,
        ST_BUSY
    } ucbt_state_type;

    function automatic logic is_dma(input logic [7:0] code);
        return (code == CMD_READ_DMA) || (code == CMD_WRITE_DMA) ||
               (code == CMD_READ_DMA_EXT) || (code == CMD_WRITE_DMA_EXT);
    endfunction

    function automatic logic is_data_out(input logic [7:0] code);
        return (code == CMD_WRITE_DMA) || (code == CMD_WRITE_DMA_EXT) ||
               (code == CMD_WRITE_SECT) || (code == CMD_WRITE_SECT_EX);
    endfunction

    function automatic logic is_security(input logic [7:0] code);
        return (code == CMD_SEC_SET_PW) || (code == CMD_SEC_UNLOCK) ||
               (code == CMD_SEC_ERASE) || (code == CMD_SEC_DIS_PW);
    endfunction
endpackage

// ==== core/ucbt_crc_if.sv ====
`timescale 1ns/1ps
interface ucbt_crc_if;
    import ucbt_pkg::*;
    logic              init;
    logic              update;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] state;
    modport engine (input init, input update, input data, output state);
    modport user   (output init, output update, output data, input state);
endinterface

// ==== core/ucbt_sync.sv ====
`timescale 1ns/1ps
module ucbt_sync
    import ucbt_pkg::*;
#(
    parameter int                WIDTH   = SYNC_W,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ==== core/ucbt_crc_engine.sv ====
`timescale 1ns/1ps
module ucbt_crc_engine
    import ucbt_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst_n,
    ucbt_crc_if.engine crc
);
    logic [DATA_W-1:0] crc_state_reg_q;
    logic [DATA_W-1:0] crc_next_value_d;
    logic [DATA_W-1:0] c;
    logic [DATA_W-1:0] d;
    logic [16:1]       f;

    assign c = crc_state_reg_q;
    assign d = crc.data;

    // Mixing terms
    assign f[1]  = d[0] ^ c[15];
    assign f[2]  = d[1] ^ c[14];
    assign f[3]  = d[2] ^ c[13];
    assign f[4]  = d[3] ^ c[12];
    assign f[5]  = d[4] ^ c[11] ^ f[1];
    assign f[6]  = d[5] ^ c[10] ^ f[2];
    assign f[7]  = d[6] ^ c[9] ^ f[3];
    assign f[8]  = d[7] ^ c[8] ^ f[4];
    assign f[9]  = d[8] ^ c[7] ^ f[5];
    assign f[10] = d[9] ^ c[6] ^ f[6];
    assign f[11] = d[10] ^ c[5] ^ f[7];
    assign f[12] = d[11] ^ c[4] ^ f[1] ^ f[8];
    assign f[13] = d[12] ^ c[3] ^ f[2] ^ f[9];
    assign f[14] = d[13] ^ c[2] ^ f[3] ^ f[10];
    assign f[15] = d[14] ^ c[1] ^ f[4] ^ f[11];
    assign f[16] = d[15] ^ c[0] ^ f[5] ^ f[12];

    // Next state, polynomial x16 + x12 + x5 + 1
    assign crc_next_value_d[0]  = f[16];
    assign crc_next_value_d[1]  = f[15];
    assign crc_next_value_d[2]  = f[14];
    assign crc_next_value_d[3]  = f[13];
    assign crc_next_value_d[4]  = f[12];
    assign crc_next_value_d[5]  = f[11] ^ f[16];
    assign crc_next_value_d[6]  = f[10] ^ f[15];
    assign crc_next_value_d[7]  = f[9] ^ f[14];
    assign crc_next_value_d[8]  = f[8] ^ f[13];
    assign crc_next_value_d[9]  = f[7] ^ f[12];
    assign crc_next_value_d[10] = f[6] ^ f[11];
    assign crc_next_value_d[11] = f[5] ^ f[10];
    assign crc_next_value_d[12] = f[4] ^ f[9] ^ f[16];
    assign crc_next_value_d[13] = f[3] ^ f[8] ^ f[15];
    assign crc_next_value_d[14] = f[2] ^ f[7] ^ f[14];
    assign crc_next_value_d[15] = f[1] ^ f[6] ^ f[13];

    // Init wins over an update in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            crc_state_reg_q <= CRC_INIT;
        end else if (crc.init) begin
            crc_state_reg_q <= CRC_INIT;
        end else if (crc.update) begin
            crc_state_reg_q <= crc_next_value_d;
        end
    end

    assign crc.state = crc_state_reg_q;
endmodule

// ==== dv/ucbt_checker.sv ====
`timescale 1ns/1ps
module ucbt_checker
    import ucbt_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              ata_reset_n,
    input wire logic              stop,
    input wire logic              dmarq,
    input wire logic              intrq,
    input wire logic              irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence st_rd;
        reg_rd && reg_addr == ADDR_STATUS;
    endsequence
    sequence cmd_wr;
        reg_wr && reg_addr == ADDR_COMMAND;
    endsequence
    sequence hrst_held;
        !ata_reset_n [*5];
    endsequence
    chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside its slot");
    chk_hrst_bsy: assert property (hrst_held ##0 st_rd |=> reg_rdata[ST_BSY_BIT])
        else $error("busy missing under hard reset");
    chk_hrst_quiet: assert property (hrst_held |-> !intrq && !dmarq)
        else $error("outputs active under hard reset");
    chk_cmd_bsy: assert property (cmd_wr ##2 st_rd |=> reg_rdata[ST_BSY_BIT])
        else $error("busy missing after command");
    chk_stat_clr: assert property (st_rd ##0 intrq |=> ##1 !intrq)
        else $error("interrupt kept after status read");
    chk_cmd_clr: assert property (cmd_wr ##0 intrq |=> ##1 !intrq)
        else $error("interrupt kept after command");
    chk_stop_dmarq: assert property (stop [*6] |-> !dmarq)
        else $error("request kept after stop");
    chk_unmapped_rd: assert property (reg_rd && reg_addr > ADDR_HOST_CRC |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    chk_mask_off: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK
        && reg_wdata[IRQ_W-1:0] == '0 ##1 !reg_wr |=> !irq)
        else $error("masked interrupt raised");
endmodule
bind udma_crc_and_busy_timing ucbt_checker CHK (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ata_reset_n(ata_reset_n), .stop(stop), .dmarq(dmarq),
    .intrq(intrq), .irq(irq));

// ==== dv/ucbt_host_model.sv ====
`timescale 1ns/1ps
module ucbt_host_model
    import ucbt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              dmarq,
    output logic                   dmack_n,
    output logic                   stop,
    output logic                   hstrobe,
    output logic      [DATA_W-1:0] dd_in
);
    logic [DATA_W-1:0] crc_q;
    initial begin
        dmack_n = 1'b1;
        stop = 1'b0;
        hstrobe = 1'b0;
        dd_in = 16'h0000;
        crc_q = CRC_INIT;
    end
    // Serial form, independent of the parallel equations; bit 0 enters first
    function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] c, d);
        for (int i = 0; i < DATA_W; i++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    task automatic burst(input int n, input logic bad);
        logic [DATA_W-1:0] d;
        for (int k = 0; k < 200 && !dmarq; k++) @(posedge sys_clk);
        @(posedge sys_clk);
        dmack_n <= 1'b0;
        crc_q = CRC_INIT;
        repeat (6) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            d = 16'($urandom);
            dd_in <= d;
            repeat (2) @(posedge sys_clk);
            hstrobe <= !hstrobe;
            crc_q = step(crc_q, d);
            repeat (2) @(posedge sys_clk);
        end
        stop <= 1'b1;
        repeat (8) @(posedge sys_clk);
        // Return edge under stop carries no word
        hstrobe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        dd_in <= bad ? ~crc_q : crc_q;
        repeat (4) @(posedge sys_clk);
        dmack_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        stop <= 1'b0;
        dd_in <= ~dd_in;
    endtask
endmodule

// ==== dv/udma_crc_and_busy_timing_tb.sv ====
`timescale 1ns/1ps
module udma_crc_and_busy_timing_tb
    import ucbt_pkg::*;
;
    localparam logic [7:0] SEC_CODES [4] = '{CMD_SEC_SET_PW, CMD_SEC_UNLOCK,
        CMD_SEC_ERASE, CMD_SEC_DIS_PW};
    localparam logic [7:0] OUT_CODES [4] = '{CMD_WRITE_SECT, CMD_WRITE_SECT_EX,
        CMD_WRITE_DMA, CMD_WRITE_DMA_EXT};
    logic              sys_clk;
    logic              rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              ata_reset_n;
    logic              dmack_n;
    logic              stop;
    logic              hstrobe;
    logic [DATA_W-1:0] dd_in;
    logic              dmarq;
    logic              intrq;
    logic              irq;
    logic              rd_seen = 1'b0;
    logic [35:0]       exp_q[$];
    logic [35:0]       ent;
    int                err_total = 0;
    int                samples_checked = 0;

    udma_crc_and_busy_timing #(.READY_CYCLES(32'h0000_0032), .DOUT_IDLE_CYCLES(32'h0000_0028),
        .DOUT_STBY_CYCLES(32'h0000_0050), .SEC_FIRST_CYCLES(32'h0000_0028)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ata_reset_n(ata_reset_n),
        .dmack_n(dmack_n), .stop(stop), .hstrobe(hstrobe), .dd_in(dd_in), .dmarq(dmarq),
        .intrq(intrq), .irq(irq));
    ucbt_host_model HOST (.sys_clk(sys_clk), .dmarq(dmarq), .dmack_n(dmack_n),
        .stop(stop), .hstrobe(hstrobe), .dd_in(dd_in));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic check(input string n, input logic [DATA_W-1:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_bit(input string n, input logic e, g);
        check(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Read data stands one cycle only, so it is taken at the next edge
    always @(posedge sys_clk) begin
        rd_seen <= reg_rd;
        if (rd_seen === 1'b1) begin
            ent = exp_q.pop_front();
            check($sformatf("reg %0h", ent[35:32]), ent[15:0], reg_rdata & ent[31:16]);
        end
    end
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, m);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) exp_q.push_back({a, m, d});
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic hard_reset();
        @(posedge sys_clk);
        ata_reset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        bus(0, ADDR_STATUS, 16'h0080, 16'h00C0);
        ata_reset_n <= 1'b1;
        repeat (60) @(posedge sys_clk);
        bus(0, ADDR_STATUS, 16'h0040, 16'h00C0);
    endtask
    task automatic deadline(input logic [7:0] code, input int lim);
        bus(1, ADDR_COMMAND, {8'h00, code}, '0);
        bus(0, ADDR_STATUS, 16'h0080, 16'h0080);
        // Deadline is exact: low one cycle before, high one cycle after
        repeat (lim - 3) @(posedge sys_clk);
        check_bit("intrq early", 1'b0, intrq);
        repeat (2) @(posedge sys_clk);
        check_bit("intrq late", 1'b1, intrq);
        bus(0, ADDR_STATUS, 16'h0041, 16'h00C1);
        repeat (3) @(posedge sys_clk);
        check_bit("intrq cleared", 1'b0, intrq);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(74596));
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ata_reset_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        bus(0, ADDR_STATUS, 16'h0080, 16'h00C0);
        repeat (60) @(posedge sys_clk);
        bus(0, ADDR_STATUS, 16'h0040, 16'h00C0);
        bus(0, 4'hF, 16'h0000, 16'hFFFF);
        bus(0, ADDR_CRC, CRC_INIT, 16'hFFFF);
        foreach (SEC_CODES[i]) begin
            hard_reset();
            deadline(SEC_CODES[i], 40);
        end
        // Odd passes run from standby, which takes the longer deadline
        foreach (OUT_CODES[i]) begin
            bus(1, ADDR_CTRL, 16'(i % 2), '0);
            deadline(OUT_CODES[i], (i % 2) ? 80 : 40);
        end
        // Deadline tests left done and timeout bits behind
        bus(1, ADDR_IRQ_STAT, 16'h000F, '0);
        bus(1, ADDR_IRQ_MASK, 16'h000F, '0);
        bus(1, ADDR_CTRL, 16'h0002, '0);
        bus(1, ADDR_COMMAND, {8'h00, CMD_READ_DMA}, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("dmarq raised", 1'b1, dmarq);
        HOST.burst(7, 1'b0);
        repeat (6) @(posedge sys_clk);
        bus(0, ADDR_CRC, HOST.crc_q, 16'hFFFF);
        bus(0, ADDR_HOST_CRC, HOST.crc_q, 16'hFFFF);
        bus(0, ADDR_IRQ_STAT, 16'h0008, 16'h000F);
        check_bit("irq burst", 1'b1, irq);
        check_bit("intrq burst", 1'b0, intrq);
        bus(1, ADDR_IRQ_STAT, 16'h0008, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("irq cleared", 1'b0, irq);
        HOST.burst(5, 1'b1);
        repeat (6) @(posedge sys_clk);
        bus(0, ADDR_CRC, HOST.crc_q, 16'hFFFF);
        bus(0, ADDR_IRQ_STAT, 16'h000A, 16'h000F);
        bus(1, ADDR_IRQ_MASK, 16'h0000, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("irq masked", 1'b0, irq);
        bus(1, ADDR_IRQ_MASK, 16'h0002, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("irq unmasked", 1'b1, irq);
        bus(1, ADDR_CTRL, 16'h0004, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("intrq done", 1'b1, intrq);
        bus(0, ADDR_STATUS, 16'h0041, 16'h00C1);
        repeat (3) @(posedge sys_clk);
        check_bit("intrq read", 1'b0, intrq);
        // A new command taken while INTRQ stands must drop it
        bus(1, ADDR_COMMAND, {8'h00, CMD_READ_DMA}, '0);
        bus(1, ADDR_CTRL, 16'h0004, '0);
        bus(1, ADDR_COMMAND, {8'h00, CMD_READ_DMA}, '0);
        repeat (3) @(posedge sys_clk);
        check_bit("intrq on command", 1'b0, intrq);
        conclude();
    end
endmodule
